// ==== core/pcg_pkg.sv ====
// Constants and types of the peripheral clock gating block
`default_nettype none
package pcg_pkg;

  localparam int PCG_DW = 32;
  localparam int PCG_AW = 12;
  localparam int PCG_NUNITS = 7;

  // Register byte offsets
  localparam logic [PCG_AW-1:0] PCG_OFS_RUN_CFG = 12'h060;
  localparam logic [PCG_AW-1:0] PCG_OFS_RUN0 = 12'h100;
  localparam logic [PCG_AW-1:0] PCG_OFS_RUN1 = 12'h104;
  localparam logic [PCG_AW-1:0] PCG_OFS_SLP0 = 12'h110;
  localparam logic [PCG_AW-1:0] PCG_OFS_SLP1 = 12'h114;
  localparam logic [PCG_AW-1:0] PCG_OFS_DSL0 = 12'h120;
  localparam logic [PCG_AW-1:0] PCG_OFS_DSL1 = 12'h124;
  localparam logic [PCG_AW-1:0] PCG_OFS_FLT_STAT = 12'h130;
  localparam logic [PCG_AW-1:0] PCG_OFS_FLT_MASK = 12'h134;

  // Field positions
  localparam int PCG_BIT_PWM = 20;
  localparam int PCG_BIT_ADC = 16;
  localparam int PCG_BIT_WDT = 3;
  localparam int PCG_BIT_TIMER_ZERO_CLK_EN = 16;
  localparam int PCG_BIT_SYNC_SERIAL_ZERO_CLK_EN = 4;
  localparam int PCG_BIT_UART_SECOND_CLK_EN = 1;
  localparam int PCG_BIT_UART_FIRST_CLK_EN = 0;
  localparam int PCG_BIT_AUTO_GATE = 27;

  // Writable bits; every other position reads zero
  localparam logic [PCG_DW-1:0] PCG_MASK_W0 = 32'h0011_0008;
  localparam logic [PCG_DW-1:0] PCG_MASK_W1 = 32'h0001_0013;
  localparam logic [PCG_DW-1:0] PCG_MASK_CFG = 32'h0800_0000;
  localparam logic [PCG_DW-1:0] PCG_RST_WORD = 32'h0000_0000;
  localparam logic [PCG_NUNITS-1:0] PCG_RST_UNITS = 7'h00;

  // Unit order on the per-unit ports: which word and bit gate each unit
  localparam int PCG_UNIT_WORD [PCG_NUNITS] = '{0, 0, 0, 1, 1, 1, 1};
  localparam int PCG_UNIT_BIT [PCG_NUNITS] = '{
    PCG_BIT_PWM, PCG_BIT_ADC, PCG_BIT_WDT,
    PCG_BIT_TIMER_ZERO_CLK_EN, PCG_BIT_SYNC_SERIAL_ZERO_CLK_EN, PCG_BIT_UART_SECOND_CLK_EN, PCG_BIT_UART_FIRST_CLK_EN};

  typedef enum logic [1:0] {
    PCG_MODE_RUN = 2'b00,
    PCG_MODE_SLEEP = 2'b01,
    PCG_MODE_DEEP = 2'b10
  } pcg_mode_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [PCG_AW-1:0] addr;
    logic [PCG_DW-1:0] wdata;
  } pcg_apb_req_t;

  typedef struct packed {
    logic [PCG_DW-1:0] word0;
    logic [PCG_DW-1:0] word1;
  } pcg_gate_pair_t;

endpackage : pcg_pkg

`default_nettype wire

// ==== core/pcg_clk_gate.sv ====
// Glitch-free clock gating cell for one peripheral clock
`timescale 1ns/1ps
`default_nettype none

module pcg_clk_gate (
  input wire logic clk_in,
  input wire logic enable,
  output logic clk_out
);

  logic en_latched;

  // Enable may only change while the clock is low, so no pulse is cut
  always_latch begin
    if (!clk_in) begin
      en_latched <= enable;
    end
  end

  assign clk_out = clk_in & en_latched;

endmodule : pcg_clk_gate

`default_nettype wire

// ==== core/pcg_top.sv ====
// Peripheral clock gating control with APB registers and fault reporting
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Set enable bit clocks its unit; cleared bit stops its clock.
// - Access to a unit whose clock is off answers with a bus fault.
// - All gating enable bits reset to zero; every unit starts unclocked.
// - Run, sleep and deep-sleep gating sets; current state's set applies.
// - Sleep sets apply only with automatic gating on; else run set stays.
// - Deep-sleep word zero bit 20 gates the pulse-width modulator clock.
// - Deep-sleep word zero bit 16 gates the first converter clock.
// - Deep-sleep word zero bit 3 gates the watchdog clock.
// - Run serial-timer word bit 16 gates timer zero.
// - Run serial-timer word bit 4 gates synchronous serial port zero.
// - Run serial-timer word bit 1 gates the second UART.
// - Run serial-timer word bit 0 gates the first UART.
// - Positions without a unit are reserved and read as zero.
module pcg_top
  import pcg_pkg::*;
#(
  parameter int NUNITS = PCG_NUNITS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [PCG_AW-1:0] PADDR,
  input wire logic [PCG_DW-1:0] PWDATA,
  output logic [PCG_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] POWER_MODE,
  input wire logic [NUNITS-1:0] UNIT_ACCESS,
  output logic UNIT_FAULT,
  output logic [NUNITS-1:0] UNIT_CLK_EN,
  output logic [NUNITS-1:0] UNIT_CLK,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus request decode

  pcg_apb_req_t req;
  logic setup_ph;
  logic access_ph;
  logic wr_done;
  logic rd_done;
  logic addr_hit;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE,
                 addr: PADDR, wdata: PWDATA};
  assign setup_ph = req.sel & ~req.enable;
  assign access_ph = req.sel & req.enable;
  assign wr_done = access_ph & req.write;
  assign rd_done = access_ph & ~req.write;

  always_comb begin
    case (req.addr)
      PCG_OFS_RUN_CFG, PCG_OFS_RUN0, PCG_OFS_RUN1,
      PCG_OFS_SLP0, PCG_OFS_SLP1, PCG_OFS_DSL0, PCG_OFS_DSL1,
      PCG_OFS_FLT_STAT, PCG_OFS_FLT_MASK: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Zero-wait slave: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access_ph & ~addr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Gating words and configuration

  pcg_gate_pair_t run_set;
  pcg_gate_pair_t slp_set;
  pcg_gate_pair_t dsl_set;
  logic [PCG_DW-1:0] run_cfg;
  pcg_gate_pair_t next_run_set;
  pcg_gate_pair_t next_slp_set;
  pcg_gate_pair_t next_dsl_set;
  logic [PCG_DW-1:0] next_run_cfg;
  logic [PCG_DW-1:0] wr_w0;
  logic [PCG_DW-1:0] wr_w1;

  // Only implemented enable bits can be written
  assign wr_w0 = req.wdata & PCG_MASK_W0;
  assign wr_w1 = req.wdata & PCG_MASK_W1;

  always_comb begin
    next_run_set = run_set;
    next_slp_set = slp_set;
    next_dsl_set = dsl_set;
    next_run_cfg = run_cfg;
    if (wr_done) begin
      case (req.addr)
        PCG_OFS_RUN0: begin
          next_run_set.word0 = wr_w0;
        end
        PCG_OFS_RUN1: begin
          next_run_set.word1 = wr_w1;
        end
        PCG_OFS_SLP0: begin
          next_slp_set.word0 = wr_w0;
        end
        PCG_OFS_SLP1: begin
          next_slp_set.word1 = wr_w1;
        end
        PCG_OFS_DSL0: begin
          next_dsl_set.word0 = wr_w0;
        end
        PCG_OFS_DSL1: begin
          next_dsl_set.word1 = wr_w1;
        end
        PCG_OFS_RUN_CFG: begin
          next_run_cfg = req.wdata & PCG_MASK_CFG;
        end
        default: begin
          next_run_cfg = run_cfg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      run_set <= '{PCG_RST_WORD, PCG_RST_WORD};
      slp_set <= '{PCG_RST_WORD, PCG_RST_WORD};
      dsl_set <= '{PCG_RST_WORD, PCG_RST_WORD};
      run_cfg <= PCG_RST_WORD;
    end else begin
      run_set <= next_run_set;
      slp_set <= next_slp_set;
      dsl_set <= next_dsl_set;
      run_cfg <= next_run_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active gating set by power state

  pcg_mode_t mode;
  pcg_gate_pair_t active_set;
  logic auto_gate;

  assign mode = pcg_mode_t'(POWER_MODE);
  assign auto_gate = run_cfg[PCG_BIT_AUTO_GATE];

  // Without automatic gating the run set stays in force while asleep
  always_comb begin
    case (mode)
      PCG_MODE_RUN: begin
        active_set = run_set;
      end
      PCG_MODE_SLEEP: begin
        active_set = auto_gate ? slp_set : run_set;
      end
      PCG_MODE_DEEP: begin
        active_set = auto_gate ? dsl_set : run_set;
      end
      default: begin
        active_set = run_set;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit enables and gated clocks

  logic [NUNITS-1:0] unit_en;
  logic [NUNITS-1:0] next_unit_en;

  genvar gi;
  generate
    for (gi = 0; gi < NUNITS; gi++) begin : g_unit
      if (PCG_UNIT_WORD[gi] == 0) begin : g_w0
        assign next_unit_en[gi] =
          active_set.word0[PCG_UNIT_BIT[gi]];
      end else begin : g_w1
        assign next_unit_en[gi] =
          active_set.word1[PCG_UNIT_BIT[gi]];
      end

      pcg_clk_gate u_gate (
        .clk_in(CLK_SYS),
        .enable(unit_en[gi]),
        .clk_out(UNIT_CLK[gi])
      );
    end
  endgenerate

  // Registered so that mode changes reach the gates one clean edge later
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      unit_en <= PCG_RST_UNITS;
    end else begin
      unit_en <= next_unit_en;
    end
  end

  assign UNIT_CLK_EN = unit_en;

  ////////////////////////////////////////////////////////////////////////////
  // Fault detection and interrupt status

  logic [NUNITS-1:0] fault_hit;
  logic [NUNITS-1:0] flt_stat;
  logic [NUNITS-1:0] flt_mask;
  logic [NUNITS-1:0] next_flt_stat;
  logic [NUNITS-1:0] next_flt_mask;
  logic stat_rd;
  logic irq;
  logic next_irq;

  // Uses the enable that the gate currently holds, not the pending one
  assign fault_hit = UNIT_ACCESS & ~unit_en;
  assign UNIT_FAULT = |fault_hit;
  assign stat_rd = rd_done & (req.addr == PCG_OFS_FLT_STAT);

  always_comb begin
    next_flt_stat = flt_stat;
    next_flt_mask = flt_mask;
    if (stat_rd) begin
      next_flt_stat = '0;
    end
    // A fault in the clearing cycle survives the read
    next_flt_stat = next_flt_stat | fault_hit;
    if (wr_done && (req.addr == PCG_OFS_FLT_MASK)) begin
      next_flt_mask = req.wdata[NUNITS-1:0];
    end
    next_irq = |(next_flt_stat & next_flt_mask);
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flt_stat <= PCG_RST_UNITS;
      flt_mask <= PCG_RST_UNITS;
      irq <= 1'b0;
    end else begin
      flt_stat <= next_flt_stat;
      flt_mask <= next_flt_mask;
      irq <= next_irq;
    end
  end

  // From a flop, so the line cannot glitch while status and mask settle
  assign IRQ = irq;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [PCG_DW-1:0] rdata;
  logic [PCG_DW-1:0] next_rdata;

  // Captured in the setup cycle so read data comes from a flop
  always_comb begin
    next_rdata = rdata;
    if (setup_ph && !req.write) begin
      case (req.addr)
        PCG_OFS_RUN_CFG: begin
          next_rdata = run_cfg;
        end
        PCG_OFS_RUN0: begin
          next_rdata = run_set.word0 & PCG_MASK_W0;
        end
        PCG_OFS_RUN1: begin
          next_rdata = run_set.word1 & PCG_MASK_W1;
        end
        PCG_OFS_SLP0: begin
          next_rdata = slp_set.word0 & PCG_MASK_W0;
        end
        PCG_OFS_SLP1: begin
          next_rdata = slp_set.word1 & PCG_MASK_W1;
        end
        PCG_OFS_DSL0: begin
          next_rdata = dsl_set.word0 & PCG_MASK_W0;
        end
        PCG_OFS_DSL1: begin
          next_rdata = dsl_set.word1 & PCG_MASK_W1;
        end
        PCG_OFS_FLT_STAT: begin
          next_rdata = {{(PCG_DW-NUNITS){1'b0}}, flt_stat | fault_hit};
        end
        PCG_OFS_FLT_MASK: begin
          next_rdata = {{(PCG_DW-NUNITS){1'b0}}, flt_mask};
        end
        default: begin
          next_rdata = PCG_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rdata <= PCG_RST_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign PRDATA = rdata;

endmodule : pcg_top

`default_nettype wire

// ==== bench/pcg_unit_model.sv ====
// Model of the gated units: counts the clock edges each unit receives
`timescale 1ns/1ps
`default_nettype none
module pcg_unit_model
  import pcg_pkg::*;
(
  input wire logic [PCG_NUNITS-1:0] unit_clk,
  input wire logic clr,
  output var int cnt [PCG_NUNITS]
);
  for (genvar i = 0; i < PCG_NUNITS; i++) begin : g_unit
    // A unit only advances on edges of its own gated clock
    always @(posedge unit_clk[i] or posedge clr) begin
      if (clr) begin
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : pcg_unit_model
`default_nettype wire

// ==== bench/pcg_top_monitor.sv ====
// Port checker of the clock gating block
`timescale 1ns/1ps
`default_nettype none
module pcg_top_monitor
  import pcg_pkg::*;
#(
  parameter int NUNITS = PCG_NUNITS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [PCG_AW-1:0] PADDR,
  input wire logic [PCG_DW-1:0] PWDATA,
  input wire logic [PCG_DW-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [1:0] POWER_MODE,
  input wire logic [NUNITS-1:0] UNIT_ACCESS,
  input wire logic UNIT_FAULT,
  input wire logic [NUNITS-1:0] UNIT_CLK_EN,
  input wire logic [NUNITS-1:0] UNIT_CLK,
  input wire logic IRQ
);
  wire logic wr = PSEL & PENABLE & PWRITE;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  chk_fault_now: assert property (
    UNIT_FAULT == |(UNIT_ACCESS & ~UNIT_CLK_EN)) else $error("bad fault");
  chk_low_phase: assert property (UNIT_CLK == '0)
    else $error("gated clock high in low phase");
  // Enable taken at a rising edge only shows from the next high phase
  chk_high_phase: assert property (
    @(negedge CLK_SYS) disable iff (!RST_N) UNIT_CLK == $past(UNIT_CLK_EN))
    else $error("gated clock wrong in high phase");
  chk_reset_off: assert property (
    $rose(RST_N) |-> UNIT_CLK_EN == '0 && !IRQ) else $error("reset state");
  chk_en_hold: assert property (
    !$past(wr) && !$past(wr, 2) && $stable(POWER_MODE)
    && $past(POWER_MODE) == $past(POWER_MODE, 2) |-> $stable(UNIT_CLK_EN))
    else $error("enable changed without cause");
  chk_err_phase: assert property (
    PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
  chk_err_zero: assert property (
    PSEL && PENABLE && !PWRITE && PSLVERR |-> PRDATA == '0)
    else $error("refused read not zero");
  chk_ready_now: assert property (
    PSEL && PENABLE |-> PREADY) else $error("access not answered");
  chk_irq_cause: assert property (
    $rose(IRQ) |-> $past(UNIT_FAULT) || $past(UNIT_FAULT, 2) || $past(wr)
    || $past(wr, 2)) else $error("interrupt without cause");
  cover property (UNIT_FAULT && IRQ);
  cover property (PSLVERR);
  cover property (POWER_MODE == 2'h2 && UNIT_CLK_EN != '0);
endmodule : pcg_top_monitor

bind pcg_top pcg_top_monitor #(.NUNITS(NUNITS)) u_mon (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_MODE(POWER_MODE),
  .UNIT_ACCESS(UNIT_ACCESS), .UNIT_FAULT(UNIT_FAULT),
  .UNIT_CLK_EN(UNIT_CLK_EN), .UNIT_CLK(UNIT_CLK), .IRQ(IRQ));
`default_nettype wire

// ==== bench/test_peripheral_clock_gating.sv ====
// Self-checking bench of the clock gating block
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_clock_gating
  import pcg_pkg::*;
;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic clr = 1'b0;
  logic [PCG_AW-1:0] PADDR = '0;
  logic [PCG_DW-1:0] PWDATA = '0;
  logic [PCG_DW-1:0] PRDATA, rd, m;
  logic PREADY, PSLVERR, UNIT_FAULT, IRQ, er;
  logic [1:0] POWER_MODE = 2'h0;
  logic [PCG_NUNITS-1:0] UNIT_ACCESS = '0;
  logic [PCG_NUNITS-1:0] UNIT_CLK_EN, UNIT_CLK, e, f;
  logic [PCG_DW-1:0] w [6];
  int cnt [PCG_NUNITS];
  int err_count = 0;
  int checks = 0;
  int seed = 11032;
  int s;
  localparam logic [PCG_AW-1:0] OFS [6] = '{PCG_OFS_RUN0, PCG_OFS_RUN1,
    PCG_OFS_SLP0, PCG_OFS_SLP1, PCG_OFS_DSL0, PCG_OFS_DSL1};

  always #5 CLK_SYS = ~CLK_SYS;

  pcg_top dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .POWER_MODE(POWER_MODE), .UNIT_ACCESS(UNIT_ACCESS),
    .UNIT_FAULT(UNIT_FAULT), .UNIT_CLK_EN(UNIT_CLK_EN),
    .UNIT_CLK(UNIT_CLK), .IRQ(IRQ));
  pcg_unit_model unit_u (.unit_clk(UNIT_CLK), .clr(clr), .cnt(cnt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Master waits on pready; result taken only at the completing edge
  task automatic apb(input logic wr, input logic [PCG_AW-1:0] a,
    input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  function automatic logic [PCG_NUNITS-1:0] ex(input logic [31:0] w0, w1);
    for (int i = 0; i < PCG_NUNITS; i++) begin
      ex[i] = PCG_UNIT_WORD[i] ? w1[PCG_UNIT_BIT[i]] : w0[PCG_UNIT_BIT[i]];
    end
  endfunction : ex

  initial begin
    #100us;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    #1;
    chk("en", UNIT_CLK_EN, '0);
    apb(0, PCG_OFS_RUN_CFG, '0);
    chk("cfg", rd, '0);
    // Pass 0 reads reset values, then all ones, then random words
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 6; i++) begin
        apb(0, OFS[i], '0);
        m = (i % 2) ? PCG_MASK_W1 : PCG_MASK_W0;
        chk("word", rd, p ? w[i] & m : '0);
        w[i] = p ? $random(seed) : '1;
        apb(1, OFS[i], w[i]);
      end
    end
    for (int a = 0; a < 2; a++) begin
      for (int md = 0; md < 4; md++) begin
        apb(1, PCG_OFS_RUN_CFG, a ? PCG_MASK_CFG : '0);
        POWER_MODE <= md[1:0];
        s = a ? (md == 1 ? 2 : md == 2 ? 4 : 0) : 0;
        e = ex(w[s], w[s + 1]);
        repeat (3) @(posedge CLK_SYS);
        #1;
        chk("en", UNIT_CLK_EN, e);
        @(posedge CLK_SYS);
        clr <= 1'b1;
        @(posedge CLK_SYS);
        clr <= 1'b0;
        repeat (8) @(posedge CLK_SYS);
        #1;
        for (int i = 0; i < PCG_NUNITS; i++) begin
          chk("clk", cnt[i], e[i] ? 8 : 0);
        end
        m = $random(seed);
        apb(1, PCG_OFS_FLT_MASK, m);
        apb(0, PCG_OFS_FLT_MASK, '0);
        chk("mask", rd, {25'h0, m[6:0]});
        f = PCG_NUNITS'($random(seed));
        @(posedge CLK_SYS);
        UNIT_ACCESS <= f;
        #1;
        chk("fault", UNIT_FAULT, |(f & ~e));
        @(posedge CLK_SYS);
        UNIT_ACCESS <= '0;
        #1;
        chk("irq", IRQ, |(f & ~e & m[6:0]));
        apb(0, PCG_OFS_FLT_STAT, '0);
        chk("stat", rd, {25'h0, f & ~e});
        #1;
        chk("irq", IRQ, 1'b0);
      end
    end
    // Read-modify-write keeps every other bit of the word as it was
    apb(0, PCG_OFS_RUN1, '0);
    apb(1, PCG_OFS_RUN1, rd | (32'h1 << PCG_BIT_SYNC_SERIAL_ZERO_CLK_EN));
    apb(0, PCG_OFS_RUN1, '0);
    chk("rmw", rd, (w[1] & PCG_MASK_W1) | (32'h1 << PCG_BIT_SYNC_SERIAL_ZERO_CLK_EN));
    // Reset in mid-run must bring the unit enables and the RUN1 word back to zero
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    #1;
    chk("en", UNIT_CLK_EN, '0);
    apb(0, PCG_OFS_RUN1, '0);
    chk("word", rd, '0);
    apb(1, 12'h200, '1);
    chk("err", er, 1'b1);
    apb(0, 12'h200, '0);
    chk("err", er, 1'b1);
    chk("rd", rd, '0);
    stop_test();
  end
endmodule : test_peripheral_clock_gating
`default_nettype wire
